// [include/rcil_pkg.sv]
// shared constants and types for the run command input logic
package rcil_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SEC_NS        = 1_000_000_000;
   localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

   localparam int unsigned NUM_TERM = 5;
   localparam int unsigned FN_W     = 14;

   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STOPM  = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_FUNC0  = 8'h0C;
   localparam logic [7:0] ADR_STEP   = 8'h04;

   localparam int unsigned CTRL_SHL_LSB  = 0;
   localparam int unsigned CTRL_COMM_BIT = 8;
   localparam int unsigned CTRL_JOG_BIT  = 9;

   localparam int unsigned STAT_ENABLE = 0;
   localparam int unsigned STAT_FWD    = 1;
   localparam int unsigned STAT_REV    = 2;
   localparam int unsigned STAT_DECEL  = 3;
   localparam int unsigned STAT_COAST  = 4;
   localparam int unsigned STAT_SECOND = 5;
   localparam int unsigned STAT_HELD   = 6;
   localparam int unsigned STAT_HOLDON = 7;

   localparam logic [FN_W-1:0] FN_SECOND  = 14'h0003;
   localparam logic [FN_W-1:0] FN_JOG     = 14'h0005;
   localparam logic [FN_W-1:0] FN_SHUTOFF = 14'h0018;
   localparam logic [FN_W-1:0] FN_HOLD    = 14'h0019;
   localparam logic [FN_W-1:0] FN_FWD     = 14'h003C;
   localparam logic [FN_W-1:0] FN_REV     = 14'h003D;
   localparam logic [FN_W-1:0] FN_NONE    = 14'h270F;

   localparam logic [2:0] SHL_NO  = 3'h0;
   localparam logic [2:0] SHL_NC  = 3'h2;
   localparam logic [2:0] SHL_MIX = 3'h4;

   localparam logic [FN_W-1:0] SM_RAMP    = 14'h270F;
   localparam logic [FN_W-1:0] SM_RAMP_SD = 14'h22B8;
   localparam logic [FN_W-1:0] SM_DLY_MAX = 14'h0064;
   localparam logic [FN_W-1:0] SM_SD_MIN  = 14'h03E8;
   localparam logic [FN_W-1:0] SM_SD_MAX  = 14'h044C;

   localparam logic [2:0]      CTRL_SHL_RST = SHL_NO;
   localparam logic [FN_W-1:0] STOPM_RST    = SM_RAMP;
   localparam logic [FN_W-1:0] FUNC0_RST    = FN_FWD;
   localparam logic [FN_W-1:0] FUNC1_RST    = FN_REV;
   localparam logic [FN_W-1:0] FUNCX_RST    = FN_NONE;

   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_RUN   = 5'b00010,
      S_DECEL = 5'b00100,
      S_WAIT  = 5'b01000,
      S_COAST = 5'b10000
   } rcil_stop_e;
endpackage

// [logic/rcil_sec_tick.sv]
// one-second enable divider, restartable
`timescale 1ns/1ps
`default_nettype none
module rcil_sec_tick
   import rcil_pkg::*;
#(
   parameter int unsigned CYCLES = SEC_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic clear_i,
   output logic      tick_o
);
   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;
   wire           wrap = (cnt_q == LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         tick_o <= wrap;
      end
   end
endmodule
`default_nettype wire

// [logic/rcil_coast_timer.sv]
// counts whole seconds down after a start-off, then flags coast
`timescale 1ns/1ps
`default_nettype none
module rcil_coast_timer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       load_i,
   input  wire logic       cancel_i,
   input  wire logic [6:0] secs_i,
   input  wire logic       tick_i,
   output logic            done_o
);
   logic [6:0] cnt_q;
   logic       armed_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || cancel_i) begin
         cnt_q   <= 7'h00;
         armed_q <= 1'b0;
         done_o  <= 1'b0;
      end else if (load_i) begin
         cnt_q   <= secs_i;
         armed_q <= 1'b1;
         done_o  <= 1'b0;
      end else begin
         done_o <= armed_q && (cnt_q == 7'h00);
         if (armed_q && cnt_q == 7'h00) begin
            armed_q <= 1'b0;
         end else if (armed_q && tick_i) begin
            cnt_q <= cnt_q - 7'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/rcil_core.sv]
// run command input decision logic with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - setting 2: terminal shutoff is normally closed, open contact cuts output
// - setting 4: terminal shutoff normally closed, communication shutoff normally open
// - setting 4: terminal ON with communication OFF permits operation
// - terminal shutoff cuts output in every mode and command source
// - shutoff while running cuts drive output at once, motor coasts
// - second-set select ON uses second parameter set
// - second-set select is attached by terminal function code 3
// - all second-set parameters switch together from one select
// - stop setting 0 to 100: coast that many seconds after start drops
// - stop setting 1000 to 1100: coast after setting minus 1000 seconds
// - stop setting 9999 or 8888: ramp down when start released
// - 1000 to 1100 or 8888: forward is start, reverse is direction
// - two-wire: one input runs that way, none or both ramp stop
// - stop input enables self-holding, direction inputs become start triggers
// - self-holding latches a start after on then off pulse
// - stop input released clears latched start and ramps down
// - stop self-holding attached by terminal function code 25
// - jog input with jog enabled makes stop input ignored
// - output shutoff leaves the latched start intact
// - forward start only on forward terminal, reverse only on reverse terminal
module rcil_core
   import rcil_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = SEC_CYCLES,
   parameter int unsigned N_TERM      = NUM_TERM
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [N_TERM-1:0] term_i,
   output logic                   drive_enable_o,
   output logic                   run_fwd_o,
   output logic                   run_rev_o,
   output logic                   decel_stop_o,
   output logic                   coast_o,
   output logic                   second_set_o
);
   // ---------------- register file ----------------
   logic [2:0]      shl_q;
   logic            comm_shut_q;
   logic            jog_en_q;
   logic [FN_W-1:0] stopm_q;
   logic [FN_W-1:0] func_q [N_TERM];

   wire        req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wr      = req && wb_we_i;
   wire [7:0]  adr_w   = {wb_adr_i[7:2], 2'b00};
   wire        hit_ctl = (adr_w == ADR_CTRL);
   wire        hit_stm = (adr_w == ADR_STOPM);
   wire [31:0] lane_m  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // current register words, merged with write lanes
   wire [31:0] ctl_cur = {22'h0, jog_en_q, comm_shut_q, 5'h00, shl_q};
   wire [31:0] ctl_new = (ctl_cur & ~lane_m) | (wb_dat_i & lane_m);
   wire [31:0] stm_new = ({18'h0, stopm_q} & ~lane_m) | (wb_dat_i & lane_m);
   wire [2:0]  shl_new = ctl_new[CTRL_SHL_LSB +: 3];
   wire [FN_W-1:0] stm_val = stm_new[FN_W-1:0];

   // unsupported values are dropped so the logic never sees them
   wire shl_ok = (shl_new == SHL_NO) || (shl_new == SHL_NC) ||
                 (shl_new == SHL_MIX);
   wire stm_ok = (stm_new[31:FN_W] == '0) &&
                 ((stm_val <= SM_DLY_MAX) || (stm_val == SM_RAMP) ||
                  (stm_val == SM_RAMP_SD) ||
                  ((stm_val >= SM_SD_MIN) && (stm_val <= SM_SD_MAX)));

   logic [31:0] status_w;
   logic [31:0] rd_mux;
   logic [N_TERM-1:0] hit_fn;
   logic [31:0] fn_rd [N_TERM];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shl_q       <= CTRL_SHL_RST;
         comm_shut_q <= 1'b0;
         jog_en_q    <= 1'b0;
         stopm_q     <= STOPM_RST;
      end else if (wr && hit_ctl) begin
         if (shl_ok) begin
            shl_q <= shl_new;
         end
         comm_shut_q <= ctl_new[CTRL_COMM_BIT];
         jog_en_q    <= ctl_new[CTRL_JOG_BIT];
      end else if (wr && hit_stm && stm_ok) begin
         stopm_q <= stm_val;
      end
   end

   // ack gates its own request, so a held cycle gets an ack every other cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // ---------------- terminal function decode ----------------
   logic [N_TERM-1:0] on_second;
   logic [N_TERM-1:0] on_jog;
   logic [N_TERM-1:0] on_shut;
   logic [N_TERM-1:0] on_hold;

   genvar g;
   generate
      for (g = 0; g < N_TERM; g++) begin : g_term
         localparam logic [7:0] MY_ADR = ADR_FUNC0 + 8'(g) * ADR_STEP;
         localparam logic [FN_W-1:0] MY_RST =
            (g == 0) ? FUNC0_RST : (g == 1) ? FUNC1_RST : FUNCX_RST;
         wire [31:0] fn_new = ({18'h0, func_q[g]} & ~lane_m) |
                              (wb_dat_i & lane_m);
         assign hit_fn[g] = (adr_w == MY_ADR);
         assign fn_rd[g]  = {18'h0, func_q[g]};
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               func_q[g] <= MY_RST;
            end else if (wr && hit_fn[g] && fn_new[31:FN_W] == '0) begin
               func_q[g] <= fn_new[FN_W-1:0];
            end
         end
         // same function on several terminals is an or
         assign on_second[g] = term_i[g] && (func_q[g] == FN_SECOND);
         assign on_jog[g]    = term_i[g] && (func_q[g] == FN_JOG);
         assign on_shut[g]   = term_i[g] && (func_q[g] == FN_SHUTOFF);
         assign on_hold[g]   = term_i[g] && (func_q[g] == FN_HOLD);
      end
   endgenerate

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctl) begin
         rd_mux = ctl_cur;
      end else if (hit_stm) begin
         rd_mux = {18'h0, stopm_q};
      end else if (adr_w == ADR_STATUS) begin
         rd_mux = status_w;
      end
      for (int i = 0; i < N_TERM; i++) begin
         if (hit_fn[i]) begin
            rd_mux = fn_rd[i];
         end
      end
   end

   wire sec_in  = |on_second;
   wire jog_in  = |on_jog;
   wire ext_in  = |on_shut;
   wire hold_in = |on_hold;
   // start codes only count on their own dedicated terminal
   wire fwd_in  = term_i[0] && (func_q[0] == FN_FWD);
   wire rev_in  = term_i[1] && (func_q[1] == FN_REV);

   // ---------------- output shutoff ----------------
   // comm command is a register bit, the terminal a contact level
   wire en_no  = !ext_in && !comm_shut_q;
   wire en_nc  = ext_in && comm_shut_q;
   wire en_mix = ext_in && !comm_shut_q;
   // terminal contact enters every setting, whatever the source
   wire op_ok  = (shl_q == SHL_NC)  ? en_nc :
                 (shl_q == SHL_MIX) ? en_mix : en_no;

   // ---------------- stop method decode ----------------
   wire sd_range = (stopm_q >= SM_SD_MIN) && (stopm_q <= SM_SD_MAX);
   wire sd_mode  = sd_range || (stopm_q == SM_RAMP_SD);
   wire ramp_m   = (stopm_q == SM_RAMP) || (stopm_q == SM_RAMP_SD);
   wire [FN_W-1:0] sd_secs = stopm_q - SM_SD_MIN;
   wire [6:0] coast_secs = sd_range ? sd_secs[6:0] : stopm_q[6:0];

   // ---------------- self-holding ----------------
   logic fwd_q;
   logic rev_q;
   logic held_q;
   logic held_rev_q;
   logic hold_on_q;

   wire hold_act = hold_in && !(jog_in && jog_en_q);
   wire fwd_fall = fwd_q && !fwd_in;
   wire rev_fall = rev_q && !rev_in && !sd_mode;
   // the releasing edge itself counts, so a fresh latch never dips into a ramp
   wire latch_now = fwd_fall || rev_fall;
   // released stop input forces a ramp even in coast settings
   wire hold_drop = hold_on_q && !hold_act && held_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_q      <= 1'b0;
         rev_q      <= 1'b0;
         held_q     <= 1'b0;
         held_rev_q <= 1'b0;
         hold_on_q  <= 1'b0;
      end else begin
         fwd_q     <= fwd_in;
         rev_q     <= rev_in;
         hold_on_q <= hold_act;
         // shutoff is not an input here, so a latch survives it
         if (!hold_act) begin
            held_q <= 1'b0;
         end else if (latch_now) begin
            held_q     <= 1'b1;
            held_rev_q <= rev_fall;
         end
      end
   end

   // ---------------- run request ----------------
   wire live_run = sd_mode ? fwd_in : (fwd_in ^ rev_in);
   wire live_rev = rev_in;
   wire held_run = held_q || latch_now;
   wire held_dir = sd_mode ? rev_in : (latch_now ? rev_fall : held_rev_q);
   wire run_req  = live_run || (hold_act && held_run);
   wire run_dir  = live_run ? live_rev : held_dir;

   // ---------------- stop sequencer ----------------
   // decel is held until the next start; the speed ramp lives outside
   rcil_stop_e st_q;
   rcil_stop_e st_d;
   logic       tmr_load;
   logic       tmr_done;
   logic       sec_tick;

   always_comb begin
      st_d     = st_q;
      tmr_load = 1'b0;
      unique case (st_q)
         S_IDLE, S_DECEL, S_COAST: begin
            if (run_req) begin
               st_d = S_RUN;
            end
         end
         S_RUN: begin
            if (!run_req) begin
               if (ramp_m || hold_drop) begin
                  st_d = S_DECEL;
               end else begin
                  st_d     = S_WAIT;
                  tmr_load = 1'b1;
               end
            end
         end
         S_WAIT: begin
            if (run_req) begin
               st_d = S_RUN;
            end else if (tmr_done) begin
               st_d = S_COAST;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   // a restart in the delay window drops the pending coast
   wire tmr_cancel = (st_q == S_WAIT) && run_req;

   // divider restarts on load, so the first counted second is whole
   rcil_sec_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (tmr_load),
      .tick_o  (sec_tick)
   );

   rcil_coast_timer u_timer (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .load_i   (tmr_load),
      .cancel_i (tmr_cancel),
      .secs_i   (coast_secs),
      .tick_i   (sec_tick),
      .done_o   (tmr_done)
   );

   // direction survives a stop, but no output reads it: running implies run_req
   logic run_dir_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q      <= S_IDLE;
         run_dir_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (run_req) begin
            run_dir_q <= run_dir;
         end
      end
   end

   // ---------------- outputs, all registered ----------------
   wire coast_d = (st_d == S_COAST);
   wire run_d   = (st_d == S_RUN);
   wire dir_d   = run_req ? run_dir : run_dir_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_enable_o <= 1'b0;
         run_fwd_o      <= 1'b0;
         run_rev_o      <= 1'b0;
         decel_stop_o   <= 1'b0;
         coast_o        <= 1'b0;
         second_set_o   <= 1'b0;
      end else begin
         // shutoff drops the bridge next edge, no ramp
         drive_enable_o <= op_ok && !coast_d;
         run_fwd_o      <= run_d && !dir_d;
         run_rev_o      <= run_d && dir_d;
         decel_stop_o   <= (st_d == S_DECEL) || (st_d == S_WAIT);
         coast_o        <= coast_d || !op_ok;
         // one select flop feeds every parameter mux, so none lag
         second_set_o   <= sec_in;
      end
   end

   // status is read only; writes to it fall through unmapped
   always_comb begin
      status_w              = 32'h0000_0000;
      status_w[STAT_ENABLE] = drive_enable_o;
      status_w[STAT_FWD]    = run_fwd_o;
      status_w[STAT_REV]    = run_rev_o;
      status_w[STAT_DECEL]  = decel_stop_o;
      status_w[STAT_COAST]  = coast_o;
      status_w[STAT_SECOND] = second_set_o;
      status_w[STAT_HELD]   = held_q;
      status_w[STAT_HOLDON] = hold_on_q;
   end
endmodule
`default_nettype wire

// [test/rcil_term_model.sv]
// external terminal contacts driven from the bench's wanted levels
`timescale 1ns/1ps
`default_nettype none
module rcil_term_model
   import rcil_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic [NUM_TERM-1:0] want_i,
   output logic      [NUM_TERM-1:0] term_o
);
   // contacts move one edge after the request, like a relay settling
   always_ff @(posedge clk_i) begin
      term_o <= want_i;
   end
endmodule
`default_nettype wire

// [test/rcil_core_props.sv]
// concurrent checks on the run command input logic ports
`timescale 1ns/1ps
`default_nettype none
module rcil_core_props
   import rcil_pkg::*;
#(
   parameter int unsigned N_TERM = NUM_TERM
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [31:0]       wb_dat_o,
   input  wire logic              wb_ack_o,
   input  wire logic [N_TERM-1:0] term_i,
   input  wire logic              drive_enable_o,
   input  wire logic              run_fwd_o,
   input  wire logic              run_rev_o,
   input  wire logic              decel_stop_o,
   input  wire logic              coast_o,
   input  wire logic              second_set_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_coast_cuts_drive: assert property (coast_o |-> !drive_enable_o)
      else $error("drive enabled while coasting");
   a_dir_exclusive: assert property (!(run_fwd_o && run_rev_o))
      else $error("both directions requested");
   a_fwd_needs_input: assert property ($rose(run_fwd_o) |-> $past(term_i[0]))
      else $error("forward run without forward input");
   a_rev_needs_input: assert property ($rose(run_rev_o) |-> $past(term_i[0] || term_i[1]))
      else $error("reverse run without start input");
   a_stop_ramps: assert property ($fell(run_fwd_o) && !run_rev_o |-> decel_stop_o || coast_o)
      else $error("forward run ended without stop action");

   c_fwd_run: cover property ($rose(run_fwd_o));
   c_coast: cover property ($rose(coast_o));
   c_second: cover property ($rose(second_set_o));
endmodule
bind rcil_core rcil_core_props #(.N_TERM(N_TERM)) i_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .term_i(term_i),
   .drive_enable_o(drive_enable_o), .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o),
   .decel_stop_o(decel_stop_o), .coast_o(coast_o), .second_set_o(second_set_o));
`default_nettype wire

// [test/testbench.sv]
// self-checking bench: register access, shutoff logic, start modes
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rcil_pkg::*;
   localparam int TICK = 8;
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
   logic wb_ack_o, drive_enable_o, run_fwd_o, run_rev_o, decel_stop_o, coast_o, second_set_o;
   logic [4:0] want = 5'h00, term_i;
   logic [5:0] outs;
   int fails = 0, checks_done = 0;
   logic [2:0] shl [3] = '{SHL_NO, SHL_NC, SHL_MIX};
   logic [4:0] tv [8] = '{5'h01, 5'h03, 5'h02, 5'h00, 5'h01, 5'h03, 5'h02, 5'h00};
   logic [5:0] ev [8] = '{6'h03, 6'h09, 6'h05, 6'h09, 6'h03, 6'h05, 6'h09, 6'h09};
   int secs [3] = '{0, 2, 2};
   logic [13:0] sm [3] = '{14'h0000, 14'h0002, 14'h03EA};
   logic en;

   assign outs = {second_set_o, coast_o, decel_stop_o, run_rev_o, run_fwd_o, drive_enable_o};
   always #50 clk_i = ~clk_i;

   rcil_core #(.TICK_CYCLES(TICK)) i_rcil_core (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .term_i(term_i), .drive_enable_o(drive_enable_o), .run_fwd_o(run_fwd_o),
      .run_rev_o(run_rev_o), .decel_stop_o(decel_stop_o), .coast_o(coast_o),
      .second_set_o(second_set_o));
   rcil_term_model i_rcil_term_model (.clk_i(clk_i), .want_i(want), .term_o(term_i));

   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // ack is seen high one edge after it is launched; release only then
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic step(input logic [4:0] v);
      @(posedge clk_i);
      want <= v;
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   initial begin
      repeat (3000) @(posedge clk_i);
      fails++;
      results();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, ADR_CTRL, 32'h0, r); chk("ctrl", 32'h0, r);
      xfer(1'b0, ADR_STOPM, 32'h0, r); chk("stopm", 32'(STOPM_RST), r);
      xfer(1'b0, ADR_FUNC0, 32'h0, r); chk("func0", 32'(FUNC0_RST), r);
      xfer(1'b0, ADR_FUNC0 + ADR_STEP, 32'h0, r); chk("func1", 32'(FUNC1_RST), r);
      xfer(1'b0, 8'h40, 32'h0, r); chk("unmapped", 32'h0, r);
      wr(ADR_STOPM, 32'h0000_01F4);
      xfer(1'b0, ADR_STOPM, 32'h0, r); chk("stopm_bad", 32'(STOPM_RST), r);
      wr(ADR_FUNC0 + 8'h08, 32'(FN_SHUTOFF));
      wr(ADR_FUNC0 + 8'h0C, 32'(FN_HOLD));
      wr(ADR_FUNC0 + 8'h10, 32'(FN_SECOND));
      for (int s = 0; s < 3; s++) begin
         for (int k = 0; k < 4; k++) begin
            wr(ADR_CTRL, {23'h0, k[0], 5'h0, shl[s]});
            step({2'b00, k[1], 2'b00});
            en = (s == 0) ? !k[1] && !k[0] : (s == 1) ? k[1] && k[0] : k[1] && !k[0];
            chk("shutoff", {26'h0, 1'b0, !en, 3'b000, en}, outs);
         end
      end
      wr(ADR_CTRL, 32'h0);
      step(5'h00);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) wr(ADR_STOPM, 32'(SM_RAMP_SD));
         step(tv[i]);
         chk("start", 32'(ev[i]), outs);
      end
      step(5'h10);
      chk("second", 32'h29, outs);
      for (int i = 0; i < 3; i++) begin
         wr(ADR_STOPM, 32'(sm[i]));
         step(5'h01);
         step(5'h00);
         if (secs[i] > 0) begin
            repeat (secs[i] * TICK - 2) @(posedge clk_i);
            #1;
            chk("coast_early", 2'b01, {coast_o, drive_enable_o});
         end
         repeat (16) @(posedge clk_i);
         #1;
         chk("coast", 2'b10, {coast_o, drive_enable_o});
      end
      wr(ADR_STOPM, 32'(SM_RAMP));
      step(5'h08);
      step(5'h09);
      step(5'h08);
      chk("held", 32'h03, outs);
      xfer(1'b0, ADR_STATUS, 32'h0, r); chk("status", 32'h0000_00C3, r);
      step(5'h0C);
      chk("held_shut", 3'b110, {run_fwd_o, coast_o, drive_enable_o});
      step(5'h08);
      chk("held_back", 3'b101, {run_fwd_o, coast_o, drive_enable_o});
      step(5'h0A);
      step(5'h08);
      chk("held_rev", 2'b10, {run_rev_o, run_fwd_o});
      step(5'h00);
      chk("hold_off", 3'b100, {decel_stop_o, run_rev_o, run_fwd_o});
      wr(ADR_FUNC0 + 8'h10, 32'(FN_JOG));
      wr(ADR_CTRL, 32'h0000_0200);
      step(5'h19);
      step(5'h18);
      chk("jog_hold", 1'b0, run_fwd_o);
      wr(ADR_CTRL, 32'h0);
      wr(ADR_FUNC0 + 8'h08, 32'(FN_FWD));
      step(5'h04);
      chk("fwd_elsewhere", 1'b0, run_fwd_o);
      results();
   end
endmodule
`default_nettype wire
